// ---- hdl/pipm_consts.vh ----
// Constants for the peripheral idle power manager.
// Assumes a 100 MHz clock and a one second time-base tick made inside the block.
`ifndef PIPM_CONSTS_VH
`define PIPM_CONSTS_VH

// Clock and time base
`define PIPM_CLK_HZ 100000000
`define PIPM_TICK_SEC 1
`define PIPM_TICK_CYCLES (`PIPM_CLK_HZ * `PIPM_TICK_SEC)

// Timer counter width in seconds
`define PIPM_SEC_W 11

// Fixed timeouts in seconds
`define PIPM_PORT_SEC 11'h01E
`define PIPM_HDD_PH2_SEC 11'h00A
`define PIPM_FLOPPY_SEC 11'h01E
`define PIPM_SEC_ZERO 11'h000
`define PIPM_SEC_ONE 11'h001

// Register map (word index; byte address is index times four)
`define PIPM_ADDR_W 4
`define PIPM_REG_CTRL 4'h0
`define PIPM_REG_VIDSEL 4'h1
`define PIPM_REG_HDDSEL 4'h2
`define PIPM_REG_CDSEL 4'h3
`define PIPM_REG_STATUS 4'h4
`define PIPM_REG_VIDCNT 4'h5
`define PIPM_REG_HDDCNT 4'h6
`define PIPM_REG_CDCNT 4'h7

// Control register fields
`define PIPM_CTRL_AC 0
`define PIPM_CTRL_CDROM 1
`define PIPM_CTRL_RESET 32'h0000_0000

// Status register fields
`define PIPM_ST_VIDSAVE 0
`define PIPM_ST_PORTSTBY 1
`define PIPM_ST_HDDSTBY 2
`define PIPM_ST_HDDOFF 3
`define PIPM_ST_CDOFF 4

// Selection register widths and reset values
`define PIPM_SEL_W 5
`define PIPM_SEL_RESET 5'h00

// I/O port addresses
`define PIPM_IO_W 10
`define PIPM_IO_HDD_BASE 10'h1F0
`define PIPM_IO_HDD_MASK 10'h3F8
`define PIPM_IO_HDD_ALT 10'h3F6
`define PIPM_IO_FDD_A 10'h3F2
`define PIPM_IO_FDD_B 10'h3F4
`define PIPM_IO_FDD_C 10'h3F5
`define PIPM_IO_CD_A 10'h3F7
`define PIPM_IO_CD_B 10'h376

// Power sequencing step times in cycles
`define PIPM_SEQ_W 8
`define PIPM_SEQ_POWER_CYC 8'h40
`define PIPM_SEQ_RESET_CYC 8'h20
`define PIPM_SEQ_ZERO 8'h00

`endif

// ---- hdl/pipm_idle_timer.v ----
// One reloadable idle countdown timer in seconds.
// Assumes tick is a one-cycle pulse once per second on the same clock.
`include "pipm_consts.vh"

module pipm_idle_timer #(
	parameter W = `PIPM_SEC_W
) (
	input wire clk,
	input wire reset_n,
	input wire tick,
	input wire retrigger,
	input wire [W-1:0] timeout,
	output reg expired,
	output reg [W-1:0] count
);

	// Retrigger reloads and wins over a tick; expiry is a single pulse at zero
	always @(posedge clk) begin
		if (!reset_n) begin
			count <= {W{1'b0}};
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (retrigger) begin
				count <= timeout;
			end else if (tick && count != {W{1'b0}}) begin
				count <= count - {{(W-1){1'b0}}, 1'b1};
				if (count == {{(W-1){1'b0}}, 1'b1})
					expired <= 1'b1;
			end
		end
	end

endmodule // pipm_idle_timer

// ---- hdl/pipm_power_manager.v ----
// Idle timers and drive power sequencing for a notebook's peripherals.
// Assumes synchronous activity strobes and a one-cycle-latency register port.
`include "pipm_consts.vh"

// What this block does
// - Assigned device activity retriggers its timer
// - Video timeouts 30s to 20min, 30min AC
// - Video expiry puts CRT and LCD saving
// - Only keyboard and mouse retrigger video
// - Ports timer 30s; standby, stop clock, decodes
// - Serial standby drives transceiver powerdown low
// - Disk phase one 10s to 5min, 30min AC
// - Fixed 10s second disk phase
// - Phase one spins down, disables interface
// - Phase two cuts power, clock, buffer
// - Ports 1F0-1F7, 3F6 retrigger disk timer
// - Disk power off drives enable low
// - Floppy 30s; CD 1 to 15min, 30min AC
// - Expiry powers drives off, tri-states, buffer off
// - Floppy and CD ports retrigger timer
// - Buffer disable drives enable_n high
// - Drive power off drives control low
// - Disk reset held until power, before interface
// - CD buffer off before power off
// - CD buffer on after power, reset
// - Shared power on while any drive active
// - CD reset before power, released before buffer
module pipm_power_manager #(
	parameter TICK_CYCLES = `PIPM_TICK_CYCLES
) (
	input wire clk,
	input wire reset_n,
	input wire [`PIPM_ADDR_W-1:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdData,
	input wire keyboardControllerActive,
	input wire mouseActive,
	input wire parallelActive,
	input wire firstSerialPortActive,
	input wire secondSerialPortActive,
	input wire infraredPortActive,
	input wire ioStrobe,
	input wire [`PIPM_IO_W-1:0] ioAddr,
	input wire externalFloppyActive,
	output reg videoPowerSave,
	output reg portStandby,
	output reg serialClockStop,
	output reg portDecodeDisable,
	output reg serial_xcvr_powerdown_n,
	output reg hddSpinDown,
	output reg hddInterfaceDisable,
	output reg hdd_power_enable,
	output reg hdd_reset_n,
	output reg hddClockStop,
	output reg hddBufferDisable,
	output reg cd_floppy_power_on,
	output reg cd_reset_n,
	output reg cd_buffer_enable_n,
	output reg driveInterfaceTristate,
	output reg ioHold
);

	// Power sequencer states
	localparam [3:0] SEQ_ON = 4'b0001;
	localparam [3:0] SEQ_OFF = 4'b0010;
	localparam [3:0] SEQ_POWER = 4'b0100;
	localparam [3:0] SEQ_RESET = 4'b1000;

	// Seconds for each selection code of the video timer
	function [`PIPM_SEC_W-1:0] videoSeconds;
		input [`PIPM_SEL_W-1:0] sel;
		input ac;
		begin
			case (sel)
				5'h00: videoSeconds = 11'h01E;
				5'h01: videoSeconds = 11'h03C;
				5'h02: videoSeconds = 11'h05A;
				5'h03: videoSeconds = 11'h078;
				5'h04: videoSeconds = 11'h096;
				5'h05: videoSeconds = 11'h0B4;
				5'h06: videoSeconds = 11'h0D2;
				5'h07: videoSeconds = 11'h0F0;
				5'h08: videoSeconds = 11'h10E;
				5'h09: videoSeconds = 11'h12C;
				5'h0A: videoSeconds = 11'h168;
				5'h0B: videoSeconds = 11'h1A4;
				5'h0C: videoSeconds = 11'h1E0;
				5'h0D: videoSeconds = 11'h21C;
				5'h0E: videoSeconds = 11'h258;
				5'h0F: videoSeconds = 11'h384;
				5'h10: videoSeconds = 11'h4B0;
				5'h11: videoSeconds = ac ? 11'h708 : 11'h4B0;
				default: videoSeconds = 11'h01E;
			endcase
		end
	endfunction

	// Seconds for each selection code of the first disk phase
	function [`PIPM_SEC_W-1:0] hddSeconds;
		input [`PIPM_SEL_W-1:0] sel;
		input ac;
		begin
			case (sel)
				5'h00: hddSeconds = 11'h00A;
				5'h01: hddSeconds = 11'h014;
				5'h02: hddSeconds = 11'h01E;
				5'h03: hddSeconds = 11'h028;
				5'h04: hddSeconds = 11'h032;
				5'h05: hddSeconds = 11'h03C;
				5'h06: hddSeconds = 11'h046;
				5'h07: hddSeconds = 11'h050;
				5'h08: hddSeconds = 11'h05A;
				5'h09: hddSeconds = 11'h078;
				5'h0A: hddSeconds = 11'h0B4;
				5'h0B: hddSeconds = 11'h0F0;
				5'h0C: hddSeconds = 11'h12C;
				5'h0D: hddSeconds = ac ? 11'h708 : 11'h12C;
				default: hddSeconds = 11'h00A;
			endcase
		end
	endfunction

	// Seconds for the floppy or CD-ROM timer
	function [`PIPM_SEC_W-1:0] cdSeconds;
		input [`PIPM_SEL_W-1:0] sel;
		input ac;
		input cdrom;
		begin
			if (!cdrom) begin
				cdSeconds = `PIPM_FLOPPY_SEC;
			end else begin
				case (sel)
					5'h00: cdSeconds = 11'h03C;
					5'h01: cdSeconds = 11'h078;
					5'h02: cdSeconds = 11'h0B4;
					5'h03: cdSeconds = 11'h0F0;
					5'h04: cdSeconds = 11'h12C;
					5'h05: cdSeconds = 11'h168;
					5'h06: cdSeconds = 11'h1A4;
					5'h07: cdSeconds = 11'h1E0;
					5'h08: cdSeconds = 11'h21C;
					5'h09: cdSeconds = 11'h258;
					5'h0A: cdSeconds = 11'h384;
					5'h0B: cdSeconds = ac ? 11'h708 : 11'h384;
					default: cdSeconds = 11'h03C;
				endcase
			end
		end
	endfunction

	reg [31:0] tickCnt_q;
	reg tick_q;
	reg [31:0] ctrl_q;
	reg [`PIPM_SEL_W-1:0] vidSel_q;
	reg [`PIPM_SEL_W-1:0] hddSel_q;
	reg [`PIPM_SEL_W-1:0] cdSel_q;
	reg [3:0] hddSeq_q;
	reg [3:0] cdSeq_q;
	reg [`PIPM_SEQ_W-1:0] hddStep_q;
	reg [`PIPM_SEQ_W-1:0] cdStep_q;
	reg hddPhase2_q;
	wire acPresent = ctrl_q[`PIPM_CTRL_AC];
	wire cdromFitted = ctrl_q[`PIPM_CTRL_CDROM];
	wire hddAccess;
	wire cdAccess;
	wire vidRetrig;
	wire portRetrig;
	wire vidExpired;
	wire portExpired;
	wire hddExpired;
	wire hdd2Expired;
	wire cdExpired;
	wire [`PIPM_SEC_W-1:0] vidCount;
	wire [`PIPM_SEC_W-1:0] hddCount;
	wire [`PIPM_SEC_W-1:0] cdCount;

	// Port address decode of the two drive groups
	assign hddAccess = ioStrobe && (((ioAddr & `PIPM_IO_HDD_MASK) == `PIPM_IO_HDD_BASE)
		|| ioAddr == `PIPM_IO_HDD_ALT);
	assign cdAccess = ioStrobe && (ioAddr == `PIPM_IO_FDD_A || ioAddr == `PIPM_IO_FDD_B
		|| ioAddr == `PIPM_IO_FDD_C || ioAddr == `PIPM_IO_CD_A
		|| ioAddr == `PIPM_IO_CD_B);
	// Video ignores display traffic on purpose
	assign vidRetrig = keyboardControllerActive || mouseActive;
	assign portRetrig = parallelActive || firstSerialPortActive
		|| secondSerialPortActive || infraredPortActive;

	// One second time base shared by all timers
	always @(posedge clk) begin
		if (!reset_n) begin
			tickCnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (tickCnt_q == TICK_CYCLES - 1) begin
			tickCnt_q <= 32'h0000_0000;
			tick_q <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	pipm_idle_timer u_vidTimer (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick_q),
		.retrigger(vidRetrig),
		.timeout(videoSeconds(vidSel_q, acPresent)),
		.expired(vidExpired),
		.count(vidCount)
	);

	pipm_idle_timer u_portTimer (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick_q),
		.retrigger(portRetrig),
		.timeout(`PIPM_PORT_SEC),
		.expired(portExpired),
		.count()
	);

	pipm_idle_timer u_hddTimer (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick_q),
		.retrigger(hddAccess),
		.timeout(hddSeconds(hddSel_q, acPresent)),
		.expired(hddExpired),
		.count(hddCount)
	);

	// Second disk phase is armed by first phase expiry
	pipm_idle_timer u_hdd2Timer (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick_q && hddPhase2_q),
		.retrigger(hddExpired || hddAccess),
		.timeout(`PIPM_HDD_PH2_SEC),
		.expired(hdd2Expired),
		.count()
	);

	pipm_idle_timer u_cdTimer (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick_q),
		.retrigger(cdAccess || externalFloppyActive),
		.timeout(cdSeconds(cdSel_q, acPresent, cdromFitted)),
		.expired(cdExpired),
		.count(cdCount)
	);

	// Register writes
	always @(posedge clk) begin
		if (!reset_n) begin
			ctrl_q <= `PIPM_CTRL_RESET;
			vidSel_q <= `PIPM_SEL_RESET;
			hddSel_q <= `PIPM_SEL_RESET;
			cdSel_q <= `PIPM_SEL_RESET;
		end else if (regWrite) begin
			case (regAddr)
				`PIPM_REG_CTRL: ctrl_q <= regWrData;
				`PIPM_REG_VIDSEL: vidSel_q <= regWrData[`PIPM_SEL_W-1:0];
				`PIPM_REG_HDDSEL: hddSel_q <= regWrData[`PIPM_SEL_W-1:0];
				`PIPM_REG_CDSEL: cdSel_q <= regWrData[`PIPM_SEL_W-1:0];
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise and when unmapped
	always @(posedge clk) begin
		if (!reset_n) begin
			regRdData <= 32'h0000_0000;
		end else if (regRead) begin
			case (regAddr)
				`PIPM_REG_CTRL: regRdData <= {30'h0000_0000, ctrl_q[1:0]};
				`PIPM_REG_VIDSEL: regRdData <= {27'h000_0000, vidSel_q};
				`PIPM_REG_HDDSEL: regRdData <= {27'h000_0000, hddSel_q};
				`PIPM_REG_CDSEL: regRdData <= {27'h000_0000, cdSel_q};
				`PIPM_REG_STATUS: regRdData <= {27'h000_0000, !cd_floppy_power_on,
					!hdd_power_enable, hddSpinDown, portStandby, videoPowerSave};
				`PIPM_REG_VIDCNT: regRdData <= {21'h00_0000, vidCount};
				`PIPM_REG_HDDCNT: regRdData <= {21'h00_0000, hddCount};
				`PIPM_REG_CDCNT: regRdData <= {21'h00_0000, cdCount};
				default: regRdData <= 32'h0000_0000;
			endcase
		end else begin
			regRdData <= 32'h0000_0000;
		end
	end

	// Video and port saving; activity wins over a same-cycle expiry
	always @(posedge clk) begin
		if (!reset_n) begin
			videoPowerSave <= 1'b0;
			portStandby <= 1'b0;
			serialClockStop <= 1'b0;
			portDecodeDisable <= 1'b0;
			serial_xcvr_powerdown_n <= 1'b1;
		end else begin
			if (vidRetrig)
				videoPowerSave <= 1'b0;
			else if (vidExpired)
				videoPowerSave <= 1'b1;
			if (portRetrig) begin
				portStandby <= 1'b0;
				serialClockStop <= 1'b0;
				portDecodeDisable <= 1'b0;
				serial_xcvr_powerdown_n <= 1'b1;
			end else if (portExpired) begin
				portStandby <= 1'b1;
				serialClockStop <= 1'b1;
				portDecodeDisable <= 1'b1;
				serial_xcvr_powerdown_n <= 1'b0;
			end
		end
	end

	// Hard disk: spin down, then power off; access powers back up in order
	always @(posedge clk) begin
		if (!reset_n) begin
			hddSeq_q <= SEQ_ON;
			hddStep_q <= `PIPM_SEQ_ZERO;
			hddPhase2_q <= 1'b0;
			hddSpinDown <= 1'b0;
			hddInterfaceDisable <= 1'b0;
			hdd_power_enable <= 1'b1;
			hdd_reset_n <= 1'b1;
			hddClockStop <= 1'b0;
			hddBufferDisable <= 1'b0;
		end else begin
			case (hddSeq_q)
				SEQ_ON: begin
					if (hddAccess) begin
						hddPhase2_q <= 1'b0;
						hddSpinDown <= 1'b0;
						hddInterfaceDisable <= 1'b0;
					end else if (hdd2Expired && hddPhase2_q) begin
						hdd_power_enable <= 1'b0;
						hddClockStop <= 1'b1;
						hddBufferDisable <= 1'b1;
						hdd_reset_n <= 1'b0;
						hddPhase2_q <= 1'b0;
						hddSeq_q <= SEQ_OFF;
					end else if (hddExpired) begin
						hddSpinDown <= 1'b1;
						hddInterfaceDisable <= 1'b1;
						hddPhase2_q <= 1'b1;
					end
				end
				SEQ_OFF: begin
					if (hddAccess) begin
						hdd_reset_n <= 1'b0;
						hdd_power_enable <= 1'b1;
						hddClockStop <= 1'b0;
						hddStep_q <= `PIPM_SEQ_POWER_CYC;
						hddSeq_q <= SEQ_POWER;
					end
				end
				SEQ_POWER: begin
					if (hddStep_q == `PIPM_SEQ_ZERO) begin
						hdd_reset_n <= 1'b1;
						hddStep_q <= `PIPM_SEQ_RESET_CYC;
						hddSeq_q <= SEQ_RESET;
					end else begin
						hddStep_q <= hddStep_q - 8'h01;
					end
				end
				SEQ_RESET: begin
					if (hddStep_q == `PIPM_SEQ_ZERO) begin
						hddBufferDisable <= 1'b0;
						hddSpinDown <= 1'b0;
						hddInterfaceDisable <= 1'b0;
						hddSeq_q <= SEQ_ON;
					end else begin
						hddStep_q <= hddStep_q - 8'h01;
					end
				end
				default: hddSeq_q <= SEQ_ON;
			endcase
		end
	end

	// Floppy and CD-ROM: buffer off first, then power; back up in reverse
	always @(posedge clk) begin
		if (!reset_n) begin
			cdSeq_q <= SEQ_ON;
			cdStep_q <= `PIPM_SEQ_ZERO;
			cd_floppy_power_on <= 1'b1;
			cd_reset_n <= 1'b1;
			cd_buffer_enable_n <= 1'b0;
			driveInterfaceTristate <= 1'b0;
		end else begin
			case (cdSeq_q)
				SEQ_ON: begin
					// External floppy activity keeps power on
					if (cdExpired && !cdAccess && !externalFloppyActive) begin
						cd_buffer_enable_n <= 1'b1;
						driveInterfaceTristate <= 1'b1;
						cdStep_q <= `PIPM_SEQ_RESET_CYC;
						cdSeq_q <= SEQ_OFF;
					end
				end
				SEQ_OFF: begin
					if (cdAccess || externalFloppyActive) begin
						if (!cd_floppy_power_on) begin
							cd_reset_n <= 1'b0;
							cd_floppy_power_on <= 1'b1;
							cdStep_q <= `PIPM_SEQ_POWER_CYC;
							cdSeq_q <= SEQ_POWER;
						end else begin
							cd_buffer_enable_n <= 1'b0;
							driveInterfaceTristate <= 1'b0;
							cdSeq_q <= SEQ_ON;
						end
					end else if (cdStep_q != `PIPM_SEQ_ZERO) begin
						cdStep_q <= cdStep_q - 8'h01; // buffer settles first
					end else if (cd_floppy_power_on) begin
						cd_floppy_power_on <= 1'b0;
						cd_reset_n <= 1'b0; // Held in reset ahead of the next power-up
					end
				end
				SEQ_POWER: begin
					if (cdStep_q == `PIPM_SEQ_ZERO) begin
						cd_reset_n <= 1'b1;
						cdStep_q <= `PIPM_SEQ_RESET_CYC;
						cdSeq_q <= SEQ_RESET;
					end else begin
						cdStep_q <= cdStep_q - 8'h01;
					end
				end
				SEQ_RESET: begin
					if (cdStep_q == `PIPM_SEQ_ZERO) begin
						cd_buffer_enable_n <= 1'b0;
						driveInterfaceTristate <= 1'b0;
						cdSeq_q <= SEQ_ON;
					end else begin
						cdStep_q <= cdStep_q - 8'h01;
					end
				end
				default: cdSeq_q <= SEQ_ON;
			endcase
		end
	end

	// Hold the pending access while either drive is coming back up
	always @(posedge clk) begin
		if (!reset_n)
			ioHold <= 1'b0;
		else
			ioHold <= (hddSeq_q != SEQ_ON && hddSeq_q != SEQ_OFF)
				|| (hddSeq_q == SEQ_OFF && hddAccess)
				|| (cdSeq_q == SEQ_POWER || cdSeq_q == SEQ_RESET)
				|| (cdSeq_q == SEQ_OFF && cdAccess && !cd_floppy_power_on);
	end

endmodule // pipm_power_manager

// ---- dv/pipm_drive_model.sv ----
// Far-side drive: usable only when powered, out of reset and linked.
// Assumes the power manager's pin levels on the same clock.
module pipm_drive_model (
	input wire logic clk,
	input wire logic powerOn,
	input wire logic resetN,
	input wire logic linkOn,
	output logic ready_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// A drive still held in reset never answers
	always @(posedge clk) begin
		ready_q <= powerOn && resetN && linkOn;
	end
endmodule // pipm_drive_model

// ---- dv/pipm_power_manager_props.sv ----
// Checker for the power manager's sequencing pins.
// Assumes one clock and a synchronous active-low reset.
module pipm_power_manager_props (
	input wire clk,
	input wire reset_n,
	input wire keyboardControllerActive,
	input wire mouseActive,
	input wire externalFloppyActive,
	input wire videoPowerSave,
	input wire portStandby,
	input wire serialClockStop,
	input wire portDecodeDisable,
	input wire serial_xcvr_powerdown_n,
	input wire hdd_power_enable,
	input wire hdd_reset_n,
	input wire hddClockStop,
	input wire hddBufferDisable,
	input wire cd_floppy_power_on,
	input wire cd_reset_n,
	input wire cd_buffer_enable_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Buffer must be shut well before the drive loses power
	property p_cdBufFirst;
		$fell(cd_floppy_power_on) |-> cd_buffer_enable_n && $past(cd_buffer_enable_n, 32);
	endproperty
	a_cdBufFirst: assert property (p_cdBufFirst) else $error("cd power cut, buffer open");
	property p_cdBufLast;
		$fell(cd_buffer_enable_n) |-> cd_floppy_power_on && cd_reset_n && $past(cd_reset_n, 8);
	endproperty
	a_cdBufLast: assert property (p_cdBufLast) else $error("cd buffer opened early");
	property p_cdRstFirst;
		$rose(cd_floppy_power_on) |-> !cd_reset_n && !$past(cd_reset_n);
	endproperty
	a_cdRstFirst: assert property (p_cdRstFirst) else $error("cd powered out of reset");
	// Disk reset spans the first cycles of power
	property p_hddRstFirst; $rose(hdd_power_enable) |-> (!hdd_reset_n) [*8]; endproperty
	a_hddRstFirst: assert property (p_hddRstFirst) else $error("disk reset too short");
	property p_hddOff; $fell(hdd_power_enable) |-> hddClockStop && hddBufferDisable; endproperty
	a_hddOff: assert property (p_hddOff) else $error("disk off, clock or buffer live");
	property p_portOff;
		$rose(portStandby) |-> ##[0:2] (!serial_xcvr_powerdown_n && serialClockStop && portDecodeDisable);
	endproperty
	a_portOff: assert property (p_portOff) else $error("port standby incomplete");
	// Only keyboard or mouse may wake the display
	property p_videoWake;
		$fell(videoPowerSave) |-> $past(keyboardControllerActive) || $past(mouseActive)
			|| $past(keyboardControllerActive, 2) || $past(mouseActive, 2);
	endproperty
	a_videoWake: assert property (p_videoWake) else $error("display woke without cause");
	property p_sharedPwr; externalFloppyActive |-> ##[0:2] cd_floppy_power_on; endproperty
	a_sharedPwr: assert property (p_sharedPwr) else $error("shared power off in use");
endmodule // pipm_power_manager_props

bind pipm_power_manager pipm_power_manager_props props_u (
	.clk(clk), .reset_n(reset_n), .keyboardControllerActive(keyboardControllerActive),
	.mouseActive(mouseActive), .externalFloppyActive(externalFloppyActive),
	.videoPowerSave(videoPowerSave), .portStandby(portStandby), .serialClockStop(serialClockStop),
	.portDecodeDisable(portDecodeDisable), .serial_xcvr_powerdown_n(serial_xcvr_powerdown_n),
	.hdd_power_enable(hdd_power_enable), .hdd_reset_n(hdd_reset_n), .hddClockStop(hddClockStop),
	.hddBufferDisable(hddBufferDisable), .cd_floppy_power_on(cd_floppy_power_on),
	.cd_reset_n(cd_reset_n), .cd_buffer_enable_n(cd_buffer_enable_n)
);

// ---- dv/pipm_power_manager_tb.sv ----
// Bench for the power manager; ten cycles stand for one second.
// Assumes a 100 MHz clock and a register port with one-cycle read latency.
module pipm_power_manager_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, regWrite, regRead, ioStrobe;
	logic [3:0] regAddr;
	logic [31:0] regWrData, regRdData;
	logic [9:0] ioAddr;
	logic [6:0] actv;
	logic videoPowerSave, portStandby, serialClockStop, portDecodeDisable, serial_xcvr_powerdown_n;
	logic hddSpinDown, hddInterfaceDisable, hdd_power_enable, hdd_reset_n, hddClockStop;
	logic hddBufferDisable, cd_floppy_power_on, cd_reset_n, cd_buffer_enable_n;
	logic driveInterfaceTristate, ioHold, hddReady, cdReady;
	wire [8:0] mon;
	int fail_count = 0;
	int n_checks = 0;
	// Watched levels by index, for bounded waits
	assign mon = {cd_buffer_enable_n, cd_reset_n, cd_floppy_power_on, hddInterfaceDisable,
		hdd_reset_n, hdd_power_enable, hddSpinDown, portStandby, videoPowerSave};

	pipm_power_manager #(.TICK_CYCLES(10)) dut_u (
		.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.keyboardControllerActive(actv[0]), .mouseActive(actv[1]), .parallelActive(actv[2]),
		.firstSerialPortActive(actv[3]), .secondSerialPortActive(actv[4]),
		.infraredPortActive(actv[5]), .externalFloppyActive(actv[6]),
		.ioStrobe(ioStrobe), .ioAddr(ioAddr), .videoPowerSave(videoPowerSave),
		.portStandby(portStandby), .serialClockStop(serialClockStop),
		.portDecodeDisable(portDecodeDisable), .serial_xcvr_powerdown_n(serial_xcvr_powerdown_n),
		.hddSpinDown(hddSpinDown), .hddInterfaceDisable(hddInterfaceDisable),
		.hdd_power_enable(hdd_power_enable), .hdd_reset_n(hdd_reset_n),
		.hddClockStop(hddClockStop), .hddBufferDisable(hddBufferDisable),
		.cd_floppy_power_on(cd_floppy_power_on), .cd_reset_n(cd_reset_n),
		.cd_buffer_enable_n(cd_buffer_enable_n), .driveInterfaceTristate(driveInterfaceTristate),
		.ioHold(ioHold)
	);
	pipm_drive_model hdd_u (.clk(clk), .powerOn(hdd_power_enable), .resetN(hdd_reset_n),
		.linkOn(!hddInterfaceDisable), .ready_q(hddReady));
	pipm_drive_model cd_u (.clk(clk), .powerOn(cd_floppy_power_on), .resetN(cd_reset_n),
		.linkOn(!cd_buffer_enable_n), .ready_q(cdReady));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task msg(input string s);
		$display("%0t test %s done", $time, s);
	endtask
	task waitBit(input int b, input logic v, input int lim);
		int i;
		i = 0;
		while (mon[b] !== v && i < lim) begin
			@(posedge clk);
			i++;
		end
		chk(mon[b], v);
	endtask
	// Bus cycles: one-cycle strobes, read data the cycle after
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask
	task io(input logic [9:0] a);
		@(posedge clk);
		ioAddr <= a;
		ioStrobe <= 1'b1;
		@(posedge clk);
		ioStrobe <= 1'b0;
	endtask
	task act(input int k);
		@(posedge clk);
		actv[k] <= 1'b1;
		@(posedge clk);
		actv[k] <= 1'b0;
	endtask
	task t_reset;
		logic [31:0] d;
		cyc(400);
		chk(mon[2:0], 0);
		chk({hdd_power_enable, cd_floppy_power_on, cd_buffer_enable_n, ioHold}, 4'hC);
		rd(4'h1, d);
		chk(d, 0);
		wr(4'h9, 32'hFFFF_FFFF);
		rd(4'h9, d);
		chk(d, 0);
		cyc(1);
		chk(regRdData, 0);
		msg("reset");
	endtask
	// Every selection of every timer, with and without mains
	task t_sel;
		logic [31:0] d;
		int e;
		for (int t = 0; t < 4; t++)
			for (int ac = 0; ac < 2; ac++)
				for (int s = 0; s < (t == 0 ? 18 : t == 1 ? 14 : t == 2 ? 12 : 1); s++) begin
					wr(4'h0, 32'(ac + 2 * (t == 2)));
					wr(4'(1 + (t > 2 ? 2 : t)), 32'(s));
					case (t)
						0: act(0);
						1: io(10'h1F0);
						2: io(10'h376);
						default: io(10'h3F2);
					endcase
					rd(4'(5 + (t > 2 ? 2 : t)), d);
					case (t)
						0: e = s < 10 ? 30 * (s + 1) : s < 15 ? 60 * (s - 4) : s == 15 ? 900
							: (s == 16 || ac == 0) ? 1200 : 1800;
						1: e = s < 9 ? 10 * (s + 1) : s < 13 ? 60 * (s - 7) : ac ? 1800 : 300;
						2: e = s < 10 ? 60 * (s + 1) : (s == 10 || ac == 0) ? 900 : 1800;
						default: e = 30;
					endcase
					chk(32'(d >= e - 1 && d <= e), 1);
				end
		msg("selections");
	endtask
	task t_video;
		wr(4'h1, 0);
		act(0);
		cyc(250);
		act(1);
		cyc(250);
		act(2);
		chk(videoPowerSave, 0);
		waitBit(0, 1, 80);
		cyc(20);
		chk(videoPowerSave, 1);
		act(0);
		cyc(3);
		chk(videoPowerSave, 0);
		msg("video");
	endtask
	task t_port;
		for (int k = 2; k < 6; k++) begin
			act(k);
			cyc(250);
			chk(portStandby, 0);
		end
		cyc(20);
		chk(portStandby, 0);
		waitBit(1, 1, 60);
		cyc(2);
		chk({serial_xcvr_powerdown_n, serialClockStop, portDecodeDisable}, 3'h3);
		act(4);
		cyc(3);
		chk({portStandby, serial_xcvr_powerdown_n}, 2'h1);
		msg("ports");
	endtask
	// Decoy address must not keep the disk awake
	task t_hdd;
		logic [31:0] d;
		wr(4'h2, 0);
		io(10'h1F0);
		cyc(60);
		io(10'h3F6);
		cyc(50);
		io(10'h1F8);
		cyc(30);
		chk(hddSpinDown, 0);
		waitBit(2, 1, 40);
		chk({hddInterfaceDisable, hdd_power_enable}, 2'h3);
		cyc(80);
		chk(hdd_power_enable, 1);
		waitBit(3, 0, 40);
		chk({hddClockStop, hddBufferDisable}, 2'h3);
		rd(4'h4, d);
		chk(d[3:2], 2'h3);
		io(10'h1F3);
		waitBit(3, 1, 3);
		chk({hdd_reset_n, ioHold}, 2'h1);
		waitBit(4, 1, 80);
		chk(hddInterfaceDisable, 1);
		waitBit(5, 0, 50);
		cyc(2);
		chk({hddReady, ioHold}, 2'h2);
		msg("disk");
	endtask
	task t_cd;
		wr(4'h0, 32'h0000_0002);
		wr(4'h3, 0);
		io(10'h376);
		cyc(300);
		io(10'h3F7);
		cyc(560);
		chk(cd_buffer_enable_n, 0);
		waitBit(8, 1, 80);
		chk({driveInterfaceTristate, cd_floppy_power_on}, 2'h3);
		waitBit(6, 0, 40);
		io(10'h376);
		waitBit(6, 1, 3);
		chk({cd_reset_n, cd_buffer_enable_n}, 2'h1);
		waitBit(7, 1, 80);
		chk(cd_buffer_enable_n, 1);
		waitBit(8, 0, 50);
		cyc(2);
		chk(cdReady, 1);
		msg("cdrom");
	endtask
	task t_floppy;
		logic [31:0] d;
		wr(4'h0, 0);
		io(10'h3F2);
		cyc(200);
		io(10'h3F4);
		cyc(200);
		io(10'h3F5);
		cyc(270);
		chk(cd_floppy_power_on, 1);
		waitBit(6, 0, 120);
		rd(4'h4, d);
		chk(d[4], 1'b1);
		@(posedge clk);
		actv[6] <= 1'b1;
		waitBit(6, 1, 120);
		cyc(400);
		chk(cd_floppy_power_on, 1);
		actv[6] <= 1'b0;
		msg("floppy");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Main sequence after twelve cycles of reset
	initial begin
		reset_n <= 1'b0;
		{regWrite, regRead, ioStrobe, regAddr, regWrData, ioAddr, actv} <= '0;
		cyc(12);
		reset_n <= 1'b1;
		t_reset;
		t_sel;
		t_video;
		t_port;
		t_hdd;
		t_cd;
		t_floppy;
		test_done;
	end
	// Whole run needs roughly five and a half thousand cycles
	initial begin
		cyc(40000);
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		test_done;
	end
endmodule // pipm_power_manager_tb
